// file: src/smcs_pkg.sv
// Constants and types of the fsm clock and config sequencer controller
// Notes on behaviour
// - After power-on write 127=0x0003, 6=0x0100, 127=0x0000, then the rest.
// - Internal mode waits for lock; external mode runs clock setup before offset correction.
// - External divider is written before the external LO is supplied.
// - Divider enable set to 3 only once a valid external LO is present.
// - Clock source select set to 1 after the divider enable.
// - Wait 100 us after selecting the external clock before offset correction.
// - Fsm clock kept between 1 or 10 MHz and 200 MHz, ideally 100 MHz.
// - Second-stage divider input kept below 1.4 GHz.
// - Offset clock is fsm clock over twice the divider; keep 0.5 to 2 MHz.
// - Pulse offset machine reset, bit 8 of register 126, on LO change.
// - After offset correction stop the clock: clear 2 bit 10, or enable to 0.
// - Pull-up enable, strength and amp bias follow the common mode voltage table.
package smcs_pkg;
	localparam int CLK_MHZ = 10;
	localparam int SETTLE_US = 100;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int WORD_W = 24;
	localparam int DATA_W = 16;
	// ----------------------------------------
	// Device register addresses
	// ----------------------------------------
	localparam logic [6:0] DA_TEST = 7'h7f;
	localparam logic [6:0] DA_INIT6 = 7'h06;
	localparam logic [6:0] DA_CLKEN = 7'h02;
	localparam logic [6:0] DA_PULLUP = 7'h4f;
	localparam logic [6:0] DA_LOCTL = 7'h51;
	localparam logic [6:0] DA_EXTDIV = 7'h52;
	localparam logic [6:0] DA_CM = 7'h53;
	localparam logic [6:0] DA_BIAS = 7'h58;
	localparam logic [6:0] DA_GAIN = 7'h5e;
	localparam logic [6:0] DA_TERM = 7'h7b;
	localparam logic [6:0] DA_OFS = 7'h7e;
	localparam logic [15:0] INIT_V0 = 16'h0003;
	localparam logic [15:0] INIT_V1 = 16'h0100;
	localparam logic [15:0] INIT_V2 = 16'h0000;
	localparam logic [15:0] CLKEN_OFF_V = 16'h0000;
	// ----------------------------------------
	// Device field positions and values
	// ----------------------------------------
	localparam int DIVEN_LSB = 6;
	localparam int SEL_BIT = 0;
	localparam int PULLUP_EN_BIT = 6;
	localparam int CM_LSB = 9;
	localparam int STR_LSB = 13;
	localparam int OFS_RST_BIT = 8;
	localparam logic [1:0] DIVEN_ON = 2'h3;
	localparam logic [1:0] DIVEN_OFF = 2'h0;
	// ----------------------------------------
	// Software register map and layout
	// ----------------------------------------
	localparam logic [7:0] SW_CTRL = 8'h00;
	localparam logic [7:0] SW_STATUS = 8'h04;
	localparam logic [7:0] SW_EXTDIV = 8'h08;
	localparam logic [7:0] SW_GAIN = 8'h0c;
	localparam logic [7:0] SW_ANALOG = 8'h10;
	localparam logic [7:0] SW_RAW = 8'h14;
	localparam logic [7:0] SW_RDATA = 8'h18;
	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_EXT_BIT = 1;
	localparam int AN_CMSEL_LSB = 2;
	localparam int AN_LVL_LSB = 6;
	localparam int AN_DIV_LSB = 9;
	localparam logic [16:0] ANALOG_RST = 17'h00200;
	localparam logic [15:0] REG16_RST = 16'h0000;
	typedef enum logic [3:0] {ST_IDLE, ST_INIT, ST_CONFIG, ST_LOCK_WAIT, ST_LO_WAIT, ST_DIV_EN,
		ST_SEL, ST_SETTLE, ST_OFS, ST_OFS_RUN, ST_CLK_OFF, ST_RAW} smcs_state_t;
endpackage

// file: src/smcs_spi_if.sv
// Handshake between the sequencer and the serial shifter
`timescale 1ns/100ps
interface smcs_spi_if;
	logic start;
	logic [23:0] word;
	logic busy;
	logic done;
	logic [15:0] rdata;
	modport ctrl(output start, output word, input busy, input done, input rdata);
	modport shft(input start, input word, output busy, output done, output rdata);
endinterface

// file: src/smcs_spi_shifter.sv
// Serial shifter: one 24-bit frame, sclk at half the system clock
`timescale 1ns/100ps
module smcs_spi_shifter
	import smcs_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	smcs_spi_if.shft bus,
	input wire logic i_muxout,
	output logic o_sck,
	output logic o_sdi,
	output logic o_cs_n
);
	logic [23:0] sh_reg;
	logic [4:0] cnt_reg;
	logic phase_reg;
	logic cs_n_reg;
	logic done_reg;
	logic [15:0] rd_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			sh_reg <= 24'h000000;
			cnt_reg <= 5'h00;
			phase_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			done_reg <= 1'b0;
		end
		else
		begin
			done_reg <= 1'b0;
			if (cs_n_reg && bus.start)
			begin
				cs_n_reg <= 1'b0;
				sh_reg <= bus.word;
				cnt_reg <= 5'h17;
			end
			else if (!cs_n_reg && !phase_reg)
				phase_reg <= 1'b1;
			else if (!cs_n_reg)
			begin
				phase_reg <= 1'b0;
				if (cnt_reg == 5'h00)
				begin
					cs_n_reg <= 1'b1;
					done_reg <= 1'b1;
				end
				else
				begin
					cnt_reg <= cnt_reg - 5'h01;
					sh_reg <= {sh_reg[22:0], 1'b0};
				end
			end
		end
	end

	// Readback bit is sampled at the falling sclk edge
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			rd_reg <= 16'h0000;
		else if (!cs_n_reg && phase_reg)
			rd_reg <= {rd_reg[14:0], i_muxout};
	end

	assign o_sck = phase_reg;
	assign o_sdi = sh_reg[23];
	assign o_cs_n = cs_n_reg;
	assign bus.busy = !cs_n_reg;
	assign bus.done = done_reg;
	assign bus.rdata = rd_reg;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	frame_len_a: assert property ($fell(cs_n_reg) |-> ##47 !cs_n_reg ##1 cs_n_reg)
		else $error("frame is not 24 sclk periods");
	sck_idle_a: assert property (cs_n_reg |-> !phase_reg)
		else $error("sclk high outside a frame");
	first_bit_a: assert property (cs_n_reg && bus.start |=> o_sdi == $past(bus.word[23]))
		else $error("first bit is not the msb");
endmodule

// file: src/smcs_top.sv
// Host-side sequencer that configures the mixer and runs its clock setup
`timescale 1ns/100ps
module smcs_top
	import smcs_pkg::*;
#(
	parameter int OFS_RUN_CYC = 1000
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_muxout,
	output logic o_sck,
	output logic o_sdi,
	output logic o_cs_n,
	input wire logic i_pll_locked,
	input wire logic i_ext_lo_valid,
	output logic o_ext_lo_supply_en,
	output logic o_busy
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// serial word layout
	function automatic logic [23:0] dev_word(input logic [6:0] a, input logic [15:0] d);
		dev_word = {1'b0, a, d};
	endfunction

	function automatic logic [15:0] lo_ctl(input logic sel, input logic [1:0] en);
		lo_ctl = (16'(en) << DIVEN_LSB) | (16'(sel) << SEL_BIT);
	endfunction

	// Returns {pull-up enable, strength, amp bias} for a common mode level code
	function automatic logic [5:0] pull_cfg(input logic [2:0] lvl);
		case (lvl)
			3'h0: pull_cfg = {1'b1, 3'h7, 2'h0};
			3'h1: pull_cfg = {1'b1, 3'h3, 2'h0};
			3'h2: pull_cfg = {1'b1, 3'h1, 2'h0};
			3'h3: pull_cfg = {1'b0, 3'h0, 2'h0};
			default: pull_cfg = {1'b0, 3'h0, 2'h3};
		endcase
	endfunction

	smcs_spi_if spi();

	smcs_spi_shifter u_shift (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.bus(spi.shft),
		.i_muxout(i_muxout),
		.o_sck(o_sck),
		.o_sdi(o_sdi),
		.o_cs_n(o_cs_n)
	);

	smcs_state_t state_reg;
	logic [2:0] step_reg;
	logic sent_reg;
	logic [15:0] wait_cnt_reg;
	logic ext_mode_reg;
	logic done_reg;
	logic supply_reg;
	logic [15:0] extdiv_reg;
	logic [15:0] gain_reg;
	logic [16:0] analog_reg;
	logic [23:0] raw_reg;
	logic [15:0] rback_reg;
	logic [31:0] rdata_reg;
	logic [23:0] cur_word;
	logic is_xfer;
	logic [2:0] last_step;
	logic [5:0] pcfg;
	logic start_cmd;
	logic raw_cmd;
	logic idle;

	// ----------------------------------------
	// Software port
	// ----------------------------------------
	assign idle = (state_reg == ST_IDLE);
	assign start_cmd = i_wr && (i_addr == SW_CTRL) && i_wdata[CTRL_GO_BIT] && idle;
	assign raw_cmd = i_wr && (i_addr == SW_RAW) && idle;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			extdiv_reg <= REG16_RST;
			gain_reg <= REG16_RST;
			analog_reg <= ANALOG_RST;
			raw_reg <= 24'h000000;
		end
		else if (i_wr)
		begin
			case (i_addr)
				// software divider codes
				// Software picks codes that keep both clocks in range; no LO rate is known here
				SW_EXTDIV: extdiv_reg <= i_wdata[15:0];
				SW_GAIN: gain_reg <= i_wdata[15:0];
				SW_ANALOG: analog_reg <= i_wdata[16:0];
				SW_RAW: if (idle) raw_reg <= i_wdata[23:0];
				default: ;
			endcase
		end
	end

	// Read data stands for exactly the cycle after the strobe
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			rdata_reg <= 32'h00000000;
		else if (i_rd)
		begin
			case (i_addr)
				SW_CTRL: rdata_reg <= {30'h0, ext_mode_reg, 1'b0};
				SW_STATUS: rdata_reg <= {24'h0, state_reg, 1'b0, supply_reg, done_reg, !idle};
				SW_EXTDIV: rdata_reg <= {16'h0, extdiv_reg};
				SW_GAIN: rdata_reg <= {16'h0, gain_reg};
				SW_ANALOG: rdata_reg <= {15'h0, analog_reg};
				SW_RAW: rdata_reg <= {8'h0, raw_reg};
				SW_RDATA: rdata_reg <= {16'h0, rback_reg};
				default: rdata_reg <= 32'h00000000;
			endcase
		end
		else
			rdata_reg <= 32'h00000000;
	end

	assign o_rdata = rdata_reg;
	assign o_busy = !idle;

	// ----------------------------------------
	// Word selection
	// ----------------------------------------
	assign pcfg = pull_cfg(analog_reg[AN_LVL_LSB +: 3]);

	always_comb
	begin
		cur_word = 24'h000000;
		is_xfer = 1'b1;
		last_step = 3'h0;
		case (state_reg)
			ST_INIT:
			begin
				last_step = 3'h2;
				case (step_reg)
					3'h0: cur_word = dev_word(DA_TEST, INIT_V0);
					3'h1: cur_word = dev_word(DA_INIT6, INIT_V1);
					default: cur_word = dev_word(DA_TEST, INIT_V2);
				endcase
			end
			ST_CONFIG:
			begin
				last_step = 3'h6;
				case (step_reg)
					3'h0: cur_word = dev_word(DA_EXTDIV, extdiv_reg);
					3'h1: cur_word = dev_word(DA_GAIN, gain_reg);
					3'h2: cur_word = dev_word(DA_TERM, {14'h0, analog_reg[1:0]});
					3'h3: cur_word = dev_word(DA_PULLUP, 16'(pcfg[5]) << PULLUP_EN_BIT);
					3'h4: cur_word = dev_word(DA_CM, (16'(pcfg[4:2]) << STR_LSB)
						| (16'(analog_reg[AN_CMSEL_LSB +: 4]) << CM_LSB));
					3'h5: cur_word = dev_word(DA_BIAS, {14'h0, pcfg[1:0]});
					default: cur_word = dev_word(DA_OFS, {8'h0, analog_reg[AN_DIV_LSB +: 8]});
				endcase
			end
			ST_DIV_EN: cur_word = dev_word(DA_LOCTL, lo_ctl(1'b0, DIVEN_ON));
			ST_SEL: cur_word = dev_word(DA_LOCTL, lo_ctl(1'b1, DIVEN_ON));
			ST_OFS:
			begin
				last_step = 3'h1;
				if (step_reg == 3'h0)
					cur_word = dev_word(DA_OFS, (16'h0001 << OFS_RST_BIT)
						| {8'h0, analog_reg[AN_DIV_LSB +: 8]});
				else
					cur_word = dev_word(DA_OFS, {8'h0, analog_reg[AN_DIV_LSB +: 8]});
			end
			ST_CLK_OFF:
			begin
				if (ext_mode_reg)
					cur_word = dev_word(DA_LOCTL, lo_ctl(1'b1, DIVEN_OFF));
				else
					cur_word = dev_word(DA_CLKEN, CLKEN_OFF_V);
			end
			ST_RAW: cur_word = raw_reg;
			default: is_xfer = 1'b0;
		endcase
	end

	assign spi.word = cur_word;
	assign spi.start = is_xfer && !sent_reg && !spi.busy;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			sent_reg <= 1'b0;
		else if (spi.done)
			sent_reg <= 1'b0;
		else if (spi.start)
			sent_reg <= 1'b1;
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_reg <= ST_IDLE;
			step_reg <= 3'h0;
			ext_mode_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					step_reg <= 3'h0;
					if (start_cmd)
					begin
						ext_mode_reg <= i_wdata[CTRL_EXT_BIT];
						state_reg <= ST_INIT;
					end
					else if (raw_cmd)
						state_reg <= ST_RAW;
				end
				ST_LOCK_WAIT: if (i_pll_locked) state_reg <= ST_OFS;
				ST_LO_WAIT: if (i_ext_lo_valid) state_reg <= ST_DIV_EN;
				ST_SETTLE:
				begin
					if (wait_cnt_reg == 16'(SETTLE_CYC - 1))
						state_reg <= ST_OFS;
				end
				ST_OFS_RUN:
					if (wait_cnt_reg == 16'(OFS_RUN_CYC - 1))
						state_reg <= ST_CLK_OFF;
				default:
				begin
					if (spi.done && step_reg != last_step)
						step_reg <= step_reg + 3'h1;
					else if (spi.done)
					begin
						step_reg <= 3'h0;
						case (state_reg)
							ST_INIT: state_reg <= ST_CONFIG;
							ST_CONFIG: state_reg <= ext_mode_reg ? ST_LO_WAIT : ST_LOCK_WAIT;
							ST_DIV_EN: state_reg <= ST_SEL;
							ST_SEL: state_reg <= ST_SETTLE;
							ST_OFS: state_reg <= ST_OFS_RUN;
							default: state_reg <= ST_IDLE;
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			wait_cnt_reg <= 16'h0000;
		else if (state_reg == ST_SETTLE || state_reg == ST_OFS_RUN)
			wait_cnt_reg <= wait_cnt_reg + 16'h0001;
		else
			wait_cnt_reg <= 16'h0000;
	end

	// Done set by the final clock-off write wins over a clear
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			done_reg <= 1'b0;
		else if (state_reg == ST_CLK_OFF && spi.done)
			done_reg <= 1'b1;
		else if (start_cmd)
			done_reg <= 1'b0;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			supply_reg <= 1'b0;
		else if (state_reg == ST_CONFIG && spi.done && step_reg == 3'h0)
			supply_reg <= ext_mode_reg;
		else if (start_cmd)
			supply_reg <= 1'b0;
	end

	assign o_ext_lo_supply_en = supply_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			rback_reg <= 16'h0000;
		else if (state_reg == ST_RAW && spi.done)
			rback_reg <= spi.rdata;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_go;
		idle && start_cmd;
	endsequence
	sequence s_first_init;
		state_reg == ST_INIT && step_reg == 3'h0 && spi.start;
	endsequence

	init_go_a: assert property (s_go |=> state_reg == ST_INIT)
		else $error("start did not enter init");
	init_first_a: assert property (s_first_init |-> cur_word == {1'b0, DA_TEST, INIT_V0})
		else $error("first init word wrong");
	init_last_a: assert property ($rose(state_reg == ST_CONFIG) |-> $past(cur_word) ==
		{1'b0, DA_TEST, INIT_V2})
		else $error("init did not end with clearing write");
	supply_order_a: assert property ($rose(supply_reg) |-> $past(state_reg) == ST_CONFIG
		&& $past(cur_word[22:16]) == DA_EXTDIV)
		else $error("LO supplied before divider write");
	enable_valid_a: assert property ($rose(state_reg == ST_DIV_EN) |-> $past(i_ext_lo_valid))
		else $error("divider enabled without valid LO");
	sel_after_en_a: assert property ($rose(state_reg == ST_SEL) |-> $past(state_reg) == ST_DIV_EN)
		else $error("select not after enable");
	settle_len_a: assert property ($fell(state_reg == ST_SETTLE) |-> $past(wait_cnt_reg) ==
		16'(SETTLE_CYC - 1) && state_reg == ST_OFS)
		else $error("settle wait wrong length");
	lock_hold_a: assert property (state_reg == ST_LOCK_WAIT && !i_pll_locked |=>
		state_reg == ST_LOCK_WAIT)
		else $error("left lock wait without lock");
	ofs_pulse_a: assert property (state_reg == ST_OFS && step_reg == 3'h1 && spi.start |->
		!cur_word[OFS_RST_BIT] && $past(state_reg == ST_OFS))
		else $error("offset reset not released");
	clk_off_a: assert property (state_reg == ST_CLK_OFF && spi.start |-> (ext_mode_reg ?
		cur_word[DIVEN_LSB +: 2] == DIVEN_OFF : cur_word[22:16] == DA_CLKEN))
		else $error("clock stop word wrong");
endmodule

// file: bench/smcs_dev_model.sv
// Behavioural mixer model: serial slave, register file and order watch
`timescale 1ns/100ps
module smcs_dev_model
	import smcs_pkg::*;
#(
	parameter int LO_DLY = 20,
	parameter int LO_MHZ = 8000,
	parameter int REF_MHZ = 100,
	parameter int CAL_DIV = 0
)
(
	input wire logic i_clk,
	input wire logic i_sck,
	input wire logic i_sdi,
	input wire logic i_cs_n,
	input wire logic i_supply_en,
	input wire logic i_locked,
	output logic o_muxout,
	output logic o_lo_valid,
	output logic o_done,
	output logic [23:0] o_word,
	output logic o_bad
);
	logic [15:0] mem [128];
	logic [23:0] sh;
	logic [6:0] ra;
	logic rwf;
	logic fr_on;
	logic cs_q;
	logic sup_q;
	logic div_ok;
	int n;
	int lo_cnt;
	int cyc;
	int sel_at;
	initial
	begin
		foreach (mem[k])
			mem[k] = 16'h0000;
		{o_muxout, o_lo_valid, o_done, o_bad, fr_on, div_ok, sup_q} = 7'h00;
		{cs_q, n, lo_cnt, cyc, sel_at} = {1'b1, 128'h0};
		o_word = 24'h000000;
	end
	// ----
	// Serial slave
	// ----
	// frame starts sck low
	always @(negedge i_cs_n)
	begin
		if (i_sck)
			o_bad = 1'b1;
		fr_on = 1'b1;
	end
	always @(posedge i_sck)
	begin
		if (!i_cs_n)
		begin
			if (n == 0)
				rwf = i_sdi;
			if (n == 7)
				ra = {sh[5:0], i_sdi};
			if (n >= 8 && rwf)
				o_muxout = mem[ra][23 - n];
			sh = {sh[22:0], i_sdi};
			n = n + 1;
		end
	end
	function automatic int a_ratio(input logic [2:0] c);
		case (c)
			3'h0: a_ratio = 1;
			3'h1: a_ratio = 2;
			3'h3: a_ratio = 4;
			3'h7: a_ratio = 8;
			default: a_ratio = 16;
		endcase
	endfunction
	// a lone device stays in sync; no sync pin or bit to model
	task automatic wr_dev(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] lc;
		int fa;
		int fsm;
		lc = mem[DA_LOCTL];
		fa = LO_MHZ / a_ratio(mem[DA_EXTDIV][5:3]);
		if (a == DA_TEST && d == INIT_V0)
			div_ok = 1'b0;
		if (a == DA_EXTDIV)
			div_ok = 1'b1;
		if (a == DA_LOCTL && d[7:6] == DIVEN_ON && !o_lo_valid)
			o_bad = 1'b1;
		if (a == DA_LOCTL && d[SEL_BIT] && !lc[SEL_BIT])
		begin
			if (lc[7:6] != DIVEN_ON)
				o_bad = 1'b1;
			sel_at = cyc;
		end
		if (a == DA_OFS && d[OFS_RST_BIT])
		begin
			if (lc[SEL_BIT] ? cyc - sel_at < SETTLE_CYC : !i_locked)
				o_bad = 1'b1;
			fsm = !lc[SEL_BIT] ? REF_MHZ >> CAL_DIV
				: lc[7:6] != DIVEN_ON ? 0 : fa >> mem[DA_EXTDIV][2:0];
			if (fsm > 200 || fsm < (lc[SEL_BIT] ? 10 : 1) || (lc[SEL_BIT] && fa >= 1400))
				o_bad = 1'b1;
		end
		mem[a] = d;
	endtask
	always @(posedge i_cs_n)
	begin
		if (fr_on)
		begin
			o_word = sh;
			if (n != WORD_W)
				o_bad = 1'b1;
			if (!sh[23])
				wr_dev(sh[22:16], sh[15:0]);
		end
		fr_on = 1'b0;
		n = 0;
	end
	// Unselected readback line keeps changing so a stale bit never passes
	always @(posedge i_clk)
	begin
		o_done <= i_cs_n & ~cs_q;
		cs_q <= i_cs_n;
		cyc <= cyc + 1;
		sup_q <= i_supply_en;
		lo_cnt <= i_supply_en ? lo_cnt + 1 : 0;
		o_lo_valid <= lo_cnt >= LO_DLY;
		if (i_supply_en && !sup_q && !div_ok)
			o_bad <= 1'b1;
		if (!fr_on)
			o_muxout <= ~o_muxout;
	end
endmodule

// file: bench/smcs_top_bench.sv
// Self-checking bench of the sequencer against the mixer model
`timescale 1ns/100ps
module smcs_top_bench
	import smcs_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic locked = 1'b0;
	logic rd_q = 1'b0;
	logic [31:0] rdata, er;
	logic [23:0] m_word, ef;
	logic muxout, sck, sdi, cs_n, lo_valid, supply, busy, m_done, m_bad;
	logic [15:0] gl;
	logic [31:0] exp_r [$];
	logic [23:0] exp_f [$];
	int errors = 0;
	int n_compared = 0;
	always #50 clk = ~clk;
	smcs_top #(.OFS_RUN_CYC(4)) dut_u (.i_clk(clk), .i_rst(rst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_muxout(muxout),
		.o_sck(sck), .o_sdi(sdi), .o_cs_n(cs_n), .i_pll_locked(locked),
		.i_ext_lo_valid(lo_valid), .o_ext_lo_supply_en(supply), .o_busy(busy));
	smcs_dev_model dev_u (.i_clk(clk), .i_sck(sck), .i_sdi(sdi), .i_cs_n(cs_n),
		.i_supply_en(supply), .i_locked(locked), .o_muxout(muxout), .o_lo_valid(lo_valid),
		.o_done(m_done), .o_word(m_word), .o_bad(m_bad));
	// ----
	// Tasks
	// ----
	task automatic miss(input string s);
		errors++;
		$display("mismatch at %0t: %s", $time, s);
	endtask
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		exp_r.push_back(e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic fr(input logic [6:0] a, input logic [15:0] d);
		exp_f.push_back({1'b0, a, d});
	endtask
	task automatic wait_idle();
		int k;
		k = 0;
		repeat (2) @(posedge clk);
		while (busy !== 1'b0 && k < 6000)
		begin
			@(posedge clk);
			k++;
		end
		if (k == 6000)
			miss("sequencer stays busy");
	endtask
	task automatic run(input logic ext, input logic [2:0] lvl);
		logic [15:0] xd;
		logic [1:0] tm;
		logic [3:0] cm;
		logic [7:0] dv;
		logic [2:0] st;
		logic [31:0] an;
		xd = 16'($urandom);
		// legal divider for the model LO
		if (ext)
			xd[5:0] = {3'h7, 3'($urandom_range(3, 6))};
		gl = 16'($urandom);
		tm = 2'($urandom);
		cm = 4'($urandom);
		dv = 8'($urandom_range(1, 255));
		st = lvl == 0 ? 3'h7 : lvl == 1 ? 3'h3 : lvl == 2 ? 3'h1 : 3'h0;
		an = {15'h0000, dv, lvl, cm, tm};
		wr_reg(SW_EXTDIV, {16'h0000, xd});
		wr_reg(SW_GAIN, {16'h0000, gl});
		wr_reg(SW_ANALOG, an);
		rd_chk(SW_ANALOG, an);
		fr(DA_TEST, INIT_V0);
		fr(DA_INIT6, INIT_V1);
		fr(DA_TEST, INIT_V2);
		fr(DA_EXTDIV, xd);
		fr(DA_GAIN, gl);
		fr(DA_TERM, {14'h0000, tm});
		fr(DA_PULLUP, {9'h000, lvl < 3, 6'h00});
		fr(DA_CM, {st, cm, 9'h000});
		fr(DA_BIAS, lvl >= 4 ? 16'h0003 : 16'h0000);
		fr(DA_OFS, {8'h00, dv});
		if (ext)
		begin
			fr(DA_LOCTL, 16'h00c0);
			fr(DA_LOCTL, 16'h00c1);
		end
		fr(DA_OFS, {8'h01, dv});
		fr(DA_OFS, {8'h00, dv});
		fr(ext ? DA_LOCTL : DA_CLKEN, ext ? 16'h0001 : CLKEN_OFF_V);
		locked <= 1'b0;
		wr_reg(SW_CTRL, {30'h0, ext, 1'b1});
		wr_reg(SW_CTRL, 32'h00000003);
		wr_reg(SW_RAW, 32'h00ffffff);
		repeat (700) @(posedge clk);
		locked <= 1'b1;
		wait_idle();
		rd_chk(SW_STATUS, {29'h0, ext, 2'b10});
		rd_chk(SW_CTRL, {30'h0, ext, 1'b0});
		rd_chk(SW_RAW, 32'h0);
		$display("test done: ext %0d level %0d", ext, lvl);
	endtask
	// ----
	// Result watcher
	// ----
	always @(posedge clk)
	begin
		rd_q <= rd;
		if (rd_q)
		begin
			n_compared++;
			er = exp_r.size() ? exp_r.pop_front() : 'x;
			if (rdata !== er)
				miss("read data");
		end
		if (m_done === 1'b1)
		begin
			n_compared++;
			ef = exp_f.size() ? exp_f.pop_front() : 'x;
			if (m_word !== ef)
				miss("serial word");
		end
	end
	initial
	begin
		repeat (60000) @(posedge clk);
		miss("watchdog expired");
		close_out();
	end
	initial
	begin
		void'($urandom(32'h5446f159));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_chk(SW_ANALOG, {15'h0000, ANALOG_RST});
		rd_chk(SW_EXTDIV, {16'h0000, REG16_RST});
		rd_chk(SW_GAIN, {16'h0000, REG16_RST});
		rd_chk(SW_STATUS, 32'h0);
		wr_reg(8'h1c, 32'hffffffff);
		rd_chk(8'h1c, 32'h0);
		$display("test done: reset values");
		for (int l = 0; l < 5; l++)
			run(1'b0, 3'(l));
		run(1'b1, 3'($urandom_range(0, 4)));
		exp_f.push_back({1'b1, DA_GAIN, 16'h0000});
		wr_reg(SW_RAW, {8'h00, 1'b1, DA_GAIN, 16'h0000});
		wait_idle();
		rd_chk(SW_RDATA, {16'h0000, gl});
		$display("test done: raw readback");
		repeat (4) @(posedge clk);
		n_compared++;
		if (m_bad !== 1'b0 || exp_f.size() != 0)
			miss("device order broken or frames missing");
		close_out();
	end
endmodule
